// ==== rtl/cif_irq_ctrl.sv ====
`timescale 1ns/10ps
module cif_irq_ctrl (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [cif_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [cif_pkg::DATA_W-1:0] I_PWDATA,
	output logic [cif_pkg::DATA_W-1:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire cif_pkg::cif_src_t I_SOURCES,
	input wire logic [1:0] I_EXT_IRQ_PIN,
	input wire cif_pkg::cif_ack_t I_ACK,
	output logic [cif_pkg::REG_W-1:0] O_CPU_REQ_LOW,
	output logic [cif_pkg::REG_W-1:0] O_CPU_REQ_HIGH,
	output logic O_IRQ
);
	import cif_pkg::*;

	logic [15:0] flags_low_q, flags_low_d;
	logic [15:0] flags_high_q, flags_high_d;
	logic [15:0] en_low_q, en_high_q;
	logic [4:0] control_q;
	logic [31:0] prdata_q;
	logic [1:0] sync1_q, sync2_q, sync3_q, pin_stable_q;
	logic [1:0] hold_q;

	wire [1:0] sp0_mode = control_q[CTL_SP0_LSB+1:CTL_SP0_LSB];
	wire [1:0] sp1_mode = control_q[CTL_SP1_LSB+1:CTL_SP1_LSB];
	wire system_clock_disable = control_q[CTL_CLKDIS_BIT];

	// APB decode; the slave never inserts wait states.
	wire hit_flags_low = (I_PADDR == FLAGS_LOW_OFS);
	wire hit_en_low = (I_PADDR == ENABLES_LOW_OFS);
	wire hit_flags_high = (I_PADDR == FLAGS_HIGH_OFS);
	wire hit_en_high = (I_PADDR == ENABLES_HIGH_OFS);
	wire hit_control = (I_PADDR == CONTROL_OFS);
	wire mapped = hit_flags_low | hit_en_low | hit_flags_high | hit_en_high | hit_control;
	wire setup_rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
	wire access_wr = I_PSEL & I_PENABLE & I_PWRITE & mapped;
	wire [15:0] wdata16 = I_PWDATA[15:0];

	// Pin filter: a level counts once the second and third stages agree.
	wire [1:0] pin_agree = ~(sync2_q ^ sync3_q);
	wire [1:0] pin_stable_d = (pin_agree & sync3_q) | (~pin_agree & pin_stable_q);
	wire [1:0] ext_fall = pin_stable_q & ~pin_stable_d;
	// Clock-off events park in the hold bits and reach the flags once enabled.
	wire [1:0] hold_set = ext_fall & {2{system_clock_disable}};
	wire [1:0] hold_release = hold_q & {2{~system_clock_disable}};
	wire [1:0] ext_set = (ext_fall & {2{~system_clock_disable}}) | hold_release;

	// Shared serial-port flags follow the port mode; modes 1x connect no source.
	wire p1_rx_src = ((sp1_mode == MODE_SDIO) & I_SOURCES.mmc1_sdio_irq) |
		((sp1_mode == MODE_I2S) & I_SOURCES.i2s1_receive_irq);
	wire p1_tx_src = ((sp1_mode == MODE_SDIO) & I_SOURCES.mmc1_irq) |
		((sp1_mode == MODE_I2S) & I_SOURCES.i2s1_transmit_irq);
	wire p0_rx_src = ((sp0_mode == MODE_SDIO) & I_SOURCES.mmc0_sdio_irq) |
		((sp0_mode == MODE_I2S) & I_SOURCES.i2s0_receive_irq);
	wire p0_tx_src = ((sp0_mode == MODE_SDIO) & I_SOURCES.mmc0_irq) |
		((sp0_mode == MODE_I2S) & I_SOURCES.i2s0_transmit_irq);

	logic [15:0] set_low, set_high;
	always_comb begin
		set_low = 16'h0000;
		set_low[BIT_S2_RX] = I_SOURCES.serial2_receive_irq;
		set_low[BIT_S2_TX] = I_SOURCES.serial2_transmit_irq;
		set_low[BIT_CONV] = I_SOURCES.converter_irq;
		set_low[BIT_DISP] = I_SOURCES.display_irq;
		set_low[BIT_P1_RX] = p1_rx_src;
		set_low[BIT_P1_TX] = p1_tx_src;
		set_low[BIT_DMA] = I_SOURCES.dma_aggregate_irq;
		set_low[BIT_P0_RX] = p0_rx_src;
		set_low[BIT_UART] = I_SOURCES.uart_irq;
		set_low[BIT_P0_TX] = p0_tx_src;
		set_low[BIT_TIMER] = I_SOURCES.timer_aggregate_irq;
		set_low[BIT_EXT1] = ext_set[1];
		set_low[BIT_EXT0] = ext_set[0];
		set_high = 16'h0000;
		set_high[BIT_RTOS] = I_SOURCES.rtos_irq;
		set_high[BIT_DATA_LOG] = I_SOURCES.data_log_irq;
		set_high[BIT_BUS_ERR] = I_SOURCES.bus_error_irq;
		set_high[BIT_I2C] = I_SOURCES.i2c_irq;
		set_high[BIT_MEM_ERR] = I_SOURCES.external_memory_if_error_irq;
		set_high[BIT_GPIO] = I_SOURCES.gpio_aggregate_irq;
		set_high[BIT_USB] = I_SOURCES.usb_irq;
		set_high[BIT_SPI] = I_SOURCES.spi_irq;
		set_high[BIT_RTC] = I_SOURCES.rtc_irq;
		set_high[BIT_S3_RX] = I_SOURCES.serial3_receive_irq;
		set_high[BIT_S3_TX] = I_SOURCES.serial3_transmit_irq;
	end

	// Service entry clears one flag; index 16 and up selects the high register.
	wire [15:0] ack_onehot = 16'h0001 << I_ACK.index[3:0];
	wire [15:0] ack_clr_low = ack_onehot & {16{I_ACK.valid & ~I_ACK.index[4]}};
	wire [15:0] ack_clr_high = ack_onehot & {16{I_ACK.valid & I_ACK.index[4]}};
	wire [15:0] sw_clr_low = wdata16 & {16{access_wr & hit_flags_low}};
	wire [15:0] sw_clr_high = wdata16 & {16{access_wr & hit_flags_high}};

	// Setting wins over either kind of clear so no event is lost.
	assign flags_low_d = ((flags_low_q & ~(sw_clr_low | ack_clr_low)) | set_low)
		& VALID_LOW_MASK;
	assign flags_high_d = ((flags_high_q & ~(sw_clr_high | ack_clr_high)) | set_high)
		& VALID_HIGH_MASK;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			flags_low_q <= FLAGS_RESET;
			flags_high_q <= FLAGS_RESET;
		end else begin
			flags_low_q <= flags_low_d;
			flags_high_q <= flags_high_d;
		end
	end

	// Reserved positions are masked off, so a careless write cannot create them.
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			en_low_q <= FLAGS_RESET;
			en_high_q <= FLAGS_RESET;
			control_q <= CONTROL_RESET;
		end else if (access_wr) begin
			if (hit_en_low) begin
				en_low_q <= wdata16 & VALID_LOW_MASK;
			end
			if (hit_en_high) begin
				en_high_q <= wdata16 & VALID_HIGH_MASK;
			end
			if (hit_control) begin
				control_q <= I_PWDATA[4:0];
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			sync1_q <= 2'h3;
			sync2_q <= 2'h3;
			sync3_q <= 2'h3;
			pin_stable_q <= 2'h3;
			hold_q <= 2'h0;
		end else begin
			sync1_q <= I_EXT_IRQ_PIN;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_stable_q <= pin_stable_d;
			hold_q <= (hold_q & ~hold_release) | hold_set;
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (1'b1)
			hit_flags_low: rd_mux = {16'h0000, flags_low_q};
			hit_en_low: rd_mux = {16'h0000, en_low_q};
			hit_flags_high: rd_mux = {16'h0000, flags_high_q};
			hit_en_high: rd_mux = {16'h0000, en_high_q};
			hit_control: rd_mux = {27'h0000000, control_q};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop.
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RESET) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata_q <= rd_mux;
		end
	end

	assign O_PRDATA = prdata_q;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
	assign O_CPU_REQ_LOW = flags_low_q & en_low_q;
	assign O_CPU_REQ_HIGH = flags_high_q & en_high_q;
	assign O_IRQ = |{O_CPU_REQ_LOW, O_CPU_REQ_HIGH};

	sequence s_pin_fall;
		pin_stable_q[0] ##1 !pin_stable_q[0];
	endsequence

	sequence s_clkoff_event;
		system_clock_disable && (ext_fall[0] || hold_q[0]);
	endsequence

	property p_req_gate;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		O_IRQ == (|(flags_low_q & en_low_q) || |(flags_high_q & en_high_q));
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("irq not flag and enable");

	property p_ext0_flag;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(s_pin_fall ##0 !system_clock_disable) |=> flags_low_q[BIT_EXT0];
	endproperty
	a_ext0_flag: assert property (p_ext0_flag) else $error("pin fall lost");

	property p_pin_filter;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		$fell(pin_stable_q[0]) |-> $past(sync2_q[0], 1) == 1'b0 && $past(sync3_q[0], 1) == 1'b0;
	endproperty
	a_pin_filter: assert property (p_pin_filter) else $error("edge without agreement");

	property p_clkoff_hold;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		s_clkoff_event |=> hold_q[0];
	endproperty
	a_clkoff_hold: assert property (p_clkoff_hold) else $error("held pin event dropped");

	property p_release_flag;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(hold_q[0] && !system_clock_disable) |=> flags_low_q[BIT_EXT0] && !hold_q[0];
	endproperty
	a_release_flag: assert property (p_release_flag) else $error("no flag on re-enable");

	property p_p0_sdio;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(sp0_mode == MODE_SDIO && I_SOURCES.mmc0_sdio_irq) |=> flags_low_q[BIT_P0_RX];
	endproperty
	a_p0_sdio: assert property (p_p0_sdio) else $error("port0 sdio not routed");

	property p_p0_i2s_tx;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(sp0_mode == MODE_I2S && !I_SOURCES.i2s0_transmit_irq && !flags_low_q[BIT_P0_TX])
		|=> !flags_low_q[BIT_P0_TX];
	endproperty
	a_p0_i2s_tx: assert property (p_p0_i2s_tx) else $error("port0 tx wrong source");

	property p_p1_route;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(sp1_mode == MODE_I2S)
		|=> (flags_low_q[BIT_P1_RX] || !$past(I_SOURCES.i2s1_receive_irq))
		&& (flags_low_q[BIT_P1_TX] || !$past(I_SOURCES.i2s1_transmit_irq));
	endproperty
	a_p1_route: assert property (p_p1_route) else $error("port1 i2s not routed");

	property p_ack_clear;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(I_ACK.valid && I_ACK.index == 5'h04 && !I_SOURCES.timer_aggregate_irq)
		|=> !flags_low_q[BIT_TIMER];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("service did not clear");

	property p_reserved_zero;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		flags_high_q[15:11] == 5'h00 && en_high_q[15:11] == 5'h00 && flags_low_q[10] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_serial2_rx;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.serial2_receive_irq |=> flags_low_q[BIT_S2_RX] [*1] ##0 !flags_high_q[15];
	endproperty
	a_serial2_rx: assert property (p_serial2_rx) else $error("serial2 rx flag missing");

	property p_serial3_tx;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.serial3_transmit_irq |=> flags_high_q[BIT_S3_TX];
	endproperty
	a_serial3_tx: assert property (p_serial3_tx) else $error("serial3 tx flag missing");

	property p_serial2_tx;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.serial2_transmit_irq |=> flags_low_q[BIT_S2_TX];
	endproperty
	a_serial2_tx: assert property (p_serial2_tx) else $error("serial2 tx flag missing");

	property p_converter;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.converter_irq |=> flags_low_q[BIT_CONV];
	endproperty
	a_converter: assert property (p_converter) else $error("converter flag missing");

	property p_display;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.display_irq |=> flags_low_q[BIT_DISP];
	endproperty
	a_display: assert property (p_display) else $error("display flag missing");

	property p_dma;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.dma_aggregate_irq |=> flags_low_q[BIT_DMA];
	endproperty
	a_dma: assert property (p_dma) else $error("dma flag missing");

	property p_uart;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.uart_irq |=> flags_low_q[BIT_UART];
	endproperty
	a_uart: assert property (p_uart) else $error("uart flag missing");

	property p_timer;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.timer_aggregate_irq |=> flags_low_q[BIT_TIMER];
	endproperty
	a_timer: assert property (p_timer) else $error("timer flag missing");

	property p_ext1_flag;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		($fell(pin_stable_q[1]) && !system_clock_disable) |=> flags_low_q[BIT_EXT1];
	endproperty
	a_ext1_flag: assert property (p_ext1_flag) else $error("pin one fall lost");

	property p_p1_sdio_tx;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(sp1_mode == MODE_SDIO && I_SOURCES.mmc1_irq) |=> flags_low_q[BIT_P1_TX];
	endproperty
	a_p1_sdio_tx: assert property (p_p1_sdio_tx) else $error("port1 card not routed");

	property p_rtos;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.rtos_irq |=> flags_high_q[BIT_RTOS];
	endproperty
	a_rtos: assert property (p_rtos) else $error("rtos flag missing");

	property p_i2c;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.i2c_irq |=> flags_high_q[BIT_I2C];
	endproperty
	a_i2c: assert property (p_i2c) else $error("i2c flag missing");

	property p_serial3_rx;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		I_SOURCES.serial3_receive_irq |=> flags_high_q[BIT_S3_RX];
	endproperty
	a_serial3_rx: assert property (p_serial3_rx) else $error("serial3 rx flag missing");

	property p_ack_high;
		@(posedge I_CLK_SYS) disable iff (I_RESET)
		(I_ACK.valid && I_ACK.index == 5'h10 && !I_SOURCES.serial3_transmit_irq)
		|=> !flags_high_q[BIT_S3_TX];
	endproperty
	a_ack_high: assert property (p_ack_high) else $error("high service did not clear");
endmodule

// ==== rtl/cif_pkg.sv ====
package cif_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;
	localparam logic [11:0] FLAGS_LOW_OFS = 12'h000;
	localparam logic [11:0] ENABLES_LOW_OFS = 12'h004;
	localparam logic [11:0] FLAGS_HIGH_OFS = 12'h008;
	localparam logic [11:0] ENABLES_HIGH_OFS = 12'h00C;
	localparam logic [11:0] CONTROL_OFS = 12'h010;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [15:0] VALID_LOW_MASK = 16'hFBFC;
	localparam logic [15:0] VALID_HIGH_MASK = 16'h07FF;
	localparam logic [4:0] CONTROL_RESET = 5'h00;
	localparam int unsigned CTL_SP0_LSB = 0;
	localparam int unsigned CTL_SP1_LSB = 2;
	localparam int unsigned CTL_CLKDIS_BIT = 4;
	localparam logic [1:0] MODE_SDIO = 2'h0;
	localparam logic [1:0] MODE_I2S = 2'h1;
	localparam int unsigned EXT_MIN_LEVEL_CYC = 2;
	localparam int unsigned BIT_S2_RX = 15;
	localparam int unsigned BIT_S2_TX = 14;
	localparam int unsigned BIT_CONV = 13;
	localparam int unsigned BIT_DISP = 12;
	localparam int unsigned BIT_P1_RX = 11;
	localparam int unsigned BIT_P1_TX = 9;
	localparam int unsigned BIT_DMA = 8;
	localparam int unsigned BIT_P0_RX = 7;
	localparam int unsigned BIT_UART = 6;
	localparam int unsigned BIT_P0_TX = 5;
	localparam int unsigned BIT_TIMER = 4;
	localparam int unsigned BIT_EXT1 = 3;
	localparam int unsigned BIT_EXT0 = 2;
	localparam int unsigned BIT_RTOS = 10;
	localparam int unsigned BIT_DATA_LOG = 9;
	localparam int unsigned BIT_BUS_ERR = 8;
	localparam int unsigned BIT_I2C = 7;
	localparam int unsigned BIT_MEM_ERR = 6;
	localparam int unsigned BIT_GPIO = 5;
	localparam int unsigned BIT_USB = 4;
	localparam int unsigned BIT_SPI = 3;
	localparam int unsigned BIT_RTC = 2;
	localparam int unsigned BIT_S3_RX = 1;
	localparam int unsigned BIT_S3_TX = 0;

	typedef struct packed {
		logic serial2_receive_irq;
		logic serial2_transmit_irq;
		logic converter_irq;
		logic display_irq;
		logic mmc1_sdio_irq;
		logic mmc1_irq;
		logic i2s1_receive_irq;
		logic i2s1_transmit_irq;
		logic dma_aggregate_irq;
		logic mmc0_sdio_irq;
		logic mmc0_irq;
		logic i2s0_receive_irq;
		logic i2s0_transmit_irq;
		logic uart_irq;
		logic timer_aggregate_irq;
		logic rtos_irq;
		logic data_log_irq;
		logic bus_error_irq;
		logic i2c_irq;
		logic external_memory_if_error_irq;
		logic gpio_aggregate_irq;
		logic usb_irq;
		logic spi_irq;
		logic rtc_irq;
		logic serial3_receive_irq;
		logic serial3_transmit_irq;
	} cif_src_t;

	typedef struct packed {
		logic valid;
		logic [4:0] index;
	} cif_ack_t;
endpackage

// ==== tb/cif_cpu_model.sv ====
`timescale 1ns/10ps
// Stands in for the CPU sequencer: it services the lowest pending request after a delay.
module cif_cpu_model (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire logic [1:0] i_delay,
	input wire logic [15:0] i_req_low,
	input wire logic [15:0] i_req_high,
	output cif_pkg::cif_ack_t o_ack
);
	import cif_pkg::*;
	int hold_q;
	function automatic logic [4:0] lowest(input logic [31:0] v);
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) lowest = 5'(i);
		end
	endfunction
	// The hold keeps a stale request from being entered twice while its flag clears.
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_ack <= '0;
			hold_q <= 0;
		end else if (o_ack.valid) begin
			o_ack <= '0;
		end else if (hold_q != 0) begin
			hold_q <= hold_q - 1;
		end else if (i_enable && {i_req_high, i_req_low} != 32'h0) begin
			o_ack <= {1'b1, lowest({i_req_high, i_req_low})};
			hold_q <= 2 + i_delay;
		end
	end
endmodule

// ==== tb/cpu_interrupt_flag_enable_test.sv ====
`timescale 1ns/10ps
module cpu_interrupt_flag_enable_test;
	import cif_pkg::*;
	logic clk, rst, psel, pen, pwr, pready, pslverr, irq, ack_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, e;
	logic [15:0] req_lo, req_hi, en_lo, en_hi;
	logic [1:0] pin, dly;
	cif_src_t src;
	cif_ack_t ack;
	logic [32:0] notes[$];
	int failures, samples_checked, n;
	// Shared bits: required mode per low source, 3 meaning any mode.
	int lb[15] = '{4, 6, 5, 7, 5, 7, 8, 9, 11, 9, 11, 12, 13, 14, 15};
	int mn[15] = '{3, 3, 1, 1, 0, 0, 3, 1, 1, 0, 0, 3, 3, 3, 3};
	cif_irq_ctrl uut (.I_CLK_SYS(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SOURCES(src), .I_EXT_IRQ_PIN(pin),
		.I_ACK(ack), .O_CPU_REQ_LOW(req_lo), .O_CPU_REQ_HIGH(req_hi), .O_IRQ(irq));
	cif_cpu_model cpu (.i_clk(clk), .i_reset(rst), .i_enable(ack_on), .i_delay(dly),
		.i_req_low(req_lo), .i_req_high(req_hi), .o_ack(ack));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task check(input logic [32:0] seen, input logic [32:0] want);
		samples_checked++;
		if (seen !== want) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task close_out;
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] want);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) notes.push_back(want);
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [15:0] want);
		apb(1'b0, a, 32'h0, {17'h0, want});
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task clear_all;
		wr(FLAGS_LOW_OFS, {16'h0, VALID_LOW_MASK});
		wr(FLAGS_HIGH_OFS, {16'h0, VALID_HIGH_MASK});
	endtask
	task pulse_src(input cif_src_t v);
		@(posedge clk);
		src <= v;
		@(posedge clk);
		src <= '0;
	endtask
	// The low level is held three clocks and the high level four so the far side keeps the minimum widths.
	task pin_fall(input int idx);
		@(posedge clk);
		pin[idx] <= 1'b0;
		repeat (3) @(posedge clk);
		pin[idx] <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [31:0] expect_of(input int k, input int m);
		logic [31:0] r;
		r = '0;
		if (k <= 10) r[16 + k] = 1'b1;
		else if (mn[k - 11] == 3 || mn[k - 11] == m) r[lb[k - 11]] = 1'b1;
		return r;
	endfunction
	always @(posedge clk) begin
		if (psel && pen && pready === 1'b1 && !pwr && notes.size() > 0)
			check({pslverr, prdata}, notes.pop_front());
	end
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		close_out;
	end
	initial begin
		{rst, psel, pen, pwr, ack_on, paddr, pwdata, dly} = {1'b1, 50'h0};
		src = '0;
		pin = 2'h3;
		void'($urandom(65));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a <= 16; a += 4) rd(12'(a), 16'h0);
		apb(1'b0, 12'h014, 32'h0, {1'b1, 32'h0});
		$display("test reset values done");
		for (int m = 0; m < 4; m++) begin
			wr(CONTROL_OFS, 32'(m * 5));
			for (int k = 0; k < 26; k++) begin
				e = expect_of(k, m);
				pulse_src(cif_src_t'(26'h1 << k));
				repeat ($urandom_range(2)) @(posedge clk);
				rd(FLAGS_LOW_OFS, e[15:0]);
				rd(FLAGS_HIGH_OFS, e[31:16]);
				clear_all;
			end
		end
		$display("test source mapping done");
		wr(CONTROL_OFS, 32'h0);
		en_lo = 16'($urandom);
		en_hi = 16'($urandom);
		wr(ENABLES_LOW_OFS, {16'h0, en_lo & VALID_LOW_MASK});
		wr(ENABLES_HIGH_OFS, {16'h0, en_hi & VALID_HIGH_MASK});
		rd(ENABLES_LOW_OFS, en_lo & 16'hFBFC);
		rd(ENABLES_HIGH_OFS, en_hi & 16'h07FF);
		pulse_src('1);
		@(negedge clk);
		check({1'b0, req_hi, req_lo}, {1'b0, en_hi & 16'h07FF, en_lo & 16'hFBF0});
		check(33'(irq), 33'(|{en_hi & 16'h07FF, en_lo & 16'hFBF0}));
		clear_all;
		@(negedge clk);
		check({irq, req_hi, req_lo}, 33'h0);
		$display("test masking done");
		wr(ENABLES_LOW_OFS, {16'h0, VALID_LOW_MASK});
		wr(ENABLES_HIGH_OFS, {16'h0, VALID_HIGH_MASK});
		pulse_src('1);
		@(posedge clk);
		dly <= 2'($urandom);
		ack_on <= 1'b1;
		n = 0;
		while (irq !== 1'b0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		ack_on <= 1'b0;
		rd(FLAGS_LOW_OFS, 16'h0);
		rd(FLAGS_HIGH_OFS, 16'h0);
		$display("test service clear done");
		for (int i = 0; i < 2; i++) begin
			pin_fall(i);
			rd(FLAGS_LOW_OFS, 16'h4 << i);
			clear_all;
		end
		for (int i = 0; i < 2; i++) begin
			wr(CONTROL_OFS, 32'h10);
			pin_fall(i);
			rd(FLAGS_LOW_OFS, 16'h0);
			wr(CONTROL_OFS, 32'h0);
			repeat (2) @(posedge clk);
			rd(FLAGS_LOW_OFS, 16'h4 << i);
			clear_all;
		end
		$display("test external pins done");
		close_out;
	end
endmodule
